// ===== dv/abs_scan_asserts.sv
/* checker: scanned controls follow the functional word outside extest.
   assumes binding onto abs_scan_cells. */
module abs_asserts (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic EXTEST_IN,
  input wire abs_pkg::abs_ctrl_t FUNC_CTRL_IN,
  input wire logic GAIN_STAGE_CLK_OUT,
  input wire logic GAIN_PATH_ENABLE_OUT,
  input wire logic CONVERTER_POWER_ON_OUT,
  input wire logic AMPLIFIER_POWER_ON_OUT,
  input wire abs_pkg::abs_dac_t DAC_WORD_OUT,
  input wire logic BYPASS_CHANNEL_ROUTE_OUT,
  input wire logic NEG_INPUT_GROUND_OUT,
  input wire logic HOLD_OUT
);
  import abs_pkg::*;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // seven cycles of functional selection cover the select path
  sequence s_fn; !EXTEST_IN [*7]; endsequence
  property p_clk; s_fn |-> GAIN_STAGE_CLK_OUT == $past(FUNC_CTRL_IN[0], 1); endproperty
  a_clk: assert property (p_clk) else $error("gain clock");
  property p_path; s_fn |-> GAIN_PATH_ENABLE_OUT == $past(FUNC_CTRL_IN[1], 1); endproperty
  a_path: assert property (p_path) else $error("gain path");
  property p_conv; s_fn ##0 $rose(FUNC_CTRL_IN[3]) |-> ##1 CONVERTER_POWER_ON_OUT; endproperty
  a_conv: assert property (p_conv) else $error("power");
  property p_amp; s_fn ##0 $fell(FUNC_CTRL_IN[4]) |-> ##1 !AMPLIFIER_POWER_ON_OUT; endproperty
  a_amp: assert property (p_amp) else $error("amp power");
  property p_dac; s_fn |-> DAC_WORD_OUT == $past(FUNC_CTRL_IN[14:5], 1); endproperty
  a_dac: assert property (p_dac) else $error("dac word");
  property p_byp; s_fn |-> BYPASS_CHANNEL_ROUTE_OUT == $past(FUNC_CTRL_IN[15], 1); endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_gnd; s_fn |-> NEG_INPUT_GROUND_OUT == $past(FUNC_CTRL_IN[18], 1); endproperty
  a_gnd: assert property (p_gnd) else $error("ground");
  property p_hold; s_fn |=> HOLD_OUT == $past(FUNC_CTRL_IN[19], 1); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind abs_scan_cells abs_asserts u_chk (.*);

// ===== dv/abs_tap_model.sv
/* test access controller model; one call is one test clock period.
   assumes callers start steps on a system clock falling edge. */
module abs_tap_model (
  output logic tck_out,
  output logic tdi_out,
  output logic shift_out,
  output logic capture_out,
  output logic update_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {tck_out, tdi_out, shift_out, capture_out, update_out} = 5'h00;
  task step(input logic [3:0] c);
    {capture_out, shift_out, update_out, tdi_out} = c;
    #80 tck_out = 1'b1;
    #80 tck_out = 1'b0;
    #40 {capture_out, shift_out, update_out} = 3'h0;
    tdi_out = ~tdi_out; // released data line does not keep its value
    #40;
  endtask
endmodule

// ===== dv/test_adc_boundary_scan_controls.sv
/* bench: functional and scanned control of the converter scan cells.
   assumes abs_tap_model on the test pins and the bound checker. */
`include "abs_map.svh"
module test_adc_boundary_scan_controls;
  timeunit 1ns;
  timeprecision 1ps;
  import abs_pkg::*;
  localparam abs_ctrl_t IDLE = 21'h08_C000;
  logic CLK_IN = 1'b0, RESET_IN = 1'b1, EXTEST_IN = 1'b0, COMPARATOR_IN = 1'b0;
  abs_ctrl_t FUNC_CTRL_IN = IDLE, w;
  logic [21:0] v;
  logic TEST_CLK_IN, SCAN_IN, SHIFT_DR_IN, CAPTURE_DR_IN, UPDATE_DR_IN, SCAN_OUT;
  logic GAIN_STAGE_CLK_OUT, GAIN_PATH_ENABLE_OUT, BANDGAP_NEG_ENABLE_OUT, HOLD_OUT;
  logic CONVERTER_POWER_ON_OUT, AMPLIFIER_POWER_ON_OUT, BYPASS_CHANNEL_ROUTE_OUT;
  logic GAIN_X10_ENABLE_OUT, GAIN_X20_ENABLE_OUT, NEG_INPUT_GROUND_OUT, SETTLED_OUT;
  logic INTERNAL_REF_ENABLE_OUT, COMPARATOR_OUT;
  abs_dac_t DAC_WORD_OUT;
  integer seed = 53604;
  int failures = 0;
  int n_checks = 0;
  abs_tap_model p (.tck_out(TEST_CLK_IN), .tdi_out(SCAN_IN), .shift_out(SHIFT_DR_IN),
    .capture_out(CAPTURE_DR_IN), .update_out(UPDATE_DR_IN));
  abs_scan_cells DUT (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .TEST_CLK_IN(TEST_CLK_IN),
    .SCAN_IN(SCAN_IN), .SHIFT_DR_IN(SHIFT_DR_IN), .CAPTURE_DR_IN(CAPTURE_DR_IN),
    .UPDATE_DR_IN(UPDATE_DR_IN), .EXTEST_IN(EXTEST_IN), .COMPARATOR_IN(COMPARATOR_IN),
    .FUNC_CTRL_IN(FUNC_CTRL_IN), .SCAN_OUT(SCAN_OUT), .GAIN_STAGE_CLK_OUT(GAIN_STAGE_CLK_OUT),
    .GAIN_PATH_ENABLE_OUT(GAIN_PATH_ENABLE_OUT),
    .BANDGAP_NEG_ENABLE_OUT(BANDGAP_NEG_ENABLE_OUT),
    .CONVERTER_POWER_ON_OUT(CONVERTER_POWER_ON_OUT),
    .AMPLIFIER_POWER_ON_OUT(AMPLIFIER_POWER_ON_OUT), .DAC_WORD_OUT(DAC_WORD_OUT),
    .BYPASS_CHANNEL_ROUTE_OUT(BYPASS_CHANNEL_ROUTE_OUT),
    .GAIN_X10_ENABLE_OUT(GAIN_X10_ENABLE_OUT), .GAIN_X20_ENABLE_OUT(GAIN_X20_ENABLE_OUT),
    .NEG_INPUT_GROUND_OUT(NEG_INPUT_GROUND_OUT), .HOLD_OUT(HOLD_OUT),
    .INTERNAL_REF_ENABLE_OUT(INTERNAL_REF_ENABLE_OUT), .COMPARATOR_OUT(COMPARATOR_OUT),
    .SETTLED_OUT(SETTLED_OUT));
  function automatic abs_ctrl_t outs();
    return {INTERNAL_REF_ENABLE_OUT, HOLD_OUT, NEG_INPUT_GROUND_OUT, GAIN_X20_ENABLE_OUT,
      GAIN_X10_ENABLE_OUT, BYPASS_CHANNEL_ROUTE_OUT, DAC_WORD_OUT, AMPLIFIER_POWER_ON_OUT,
      CONVERTER_POWER_ON_OUT, BANDGAP_NEG_ENABLE_OUT, GAIN_PATH_ENABLE_OUT, GAIN_STAGE_CLK_OUT};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #10 CLK_IN = ~CLK_IN;
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge CLK_IN);
    chk(outs(), IDLE);
    RESET_IN = 1'b0;
    for (int i = 0; i < 10; i++) begin
      FUNC_CTRL_IN = i == 8 ? '1 : i == 9 ? '0 : 21'($random(seed));
      repeat (4) @(negedge CLK_IN);
      chk(outs(), FUNC_CTRL_IN);
    end
    FUNC_CTRL_IN = IDLE | 21'h8;
    repeat (8) @(negedge CLK_IN);
    chk(SETTLED_OUT, 0);
    repeat (10) @(negedge CLK_IN);
    chk(SETTLED_OUT, 1);
    FUNC_CTRL_IN[14:5] = 10'h0F0;
    repeat (4) @(negedge CLK_IN);
    chk(COMPARATOR_OUT, 0);
    FUNC_CTRL_IN[14:5] = 10'h310;
    COMPARATOR_IN = 1'b1;
    repeat (4) @(negedge CLK_IN);
    chk(COMPARATOR_OUT, 1);
    chk(DAC_WORD_OUT, 10'h310);
    EXTEST_IN = 1'b1;
    w = 21'($random(seed));
    w[`ABS_POS_HOLD] = w[`ABS_POS_HOLD] & w[`ABS_POS_GAIN_CLK];
    if (!w[`ABS_POS_HOLD]) w[14:5] = `ABS_DAC_MIDSCALE;
    w[`ABS_POS_NEG_GND] = w[`ABS_POS_NEG_GND] & ~w[`ABS_POS_BANDGAP_NEG];
    w[`ABS_POS_GAIN_PATH] = w[`ABS_POS_GAIN_PATH] & ~w[`ABS_POS_BANDGAP_NEG] & ~w[`ABS_POS_NEG_GND];
    v = {w, 1'b0};
    repeat (6) @(negedge CLK_IN);
    p.step(4'b1000);
    chk(SCAN_OUT, 1);
    for (int i = 0; i < 22; i++) p.step({3'b010, v[i]});
    p.step(4'b0010);
    repeat (2) @(negedge CLK_IN);
    chk(outs(), w);
    chk(COMPARATOR_OUT, 1);
    wrap_up();
  end
endmodule

// ===== rtl/abs_map.svh
/*
  constants for the converter scan cells: chain layout, reset values, timing.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef ABS_MAP_SVH
`define ABS_MAP_SVH

// control cell positions in the chain, scan-out end first
`define ABS_POS_GAIN_CLK 0
`define ABS_POS_GAIN_PATH 1
`define ABS_POS_BANDGAP_NEG 2
`define ABS_POS_CONV_PWR 3
`define ABS_POS_AMP_PWR 4
`define ABS_POS_DAC_LSB 5
`define ABS_POS_BYPASS 15
`define ABS_POS_GAIN_X10 16
`define ABS_POS_GAIN_X20 17
`define ABS_POS_NEG_GND 18
`define ABS_POS_HOLD 19
`define ABS_POS_IREF 20
`define ABS_NUM_CTRL 21
`define ABS_DAC_BITS 10
// recommended idle values: dac midscale, bypass 1, hold 1, all else 0
`define ABS_CTRL_RESET 21'h08_C000
`define ABS_DAC_MIDSCALE 10'h200
`define ABS_SYNC_STAGES 2
`define ABS_CLK_PERIOD_NS 20
`define ABS_SETTLE_NS 200
`define ABS_SETTLE_CYC ((`ABS_SETTLE_NS + `ABS_CLK_PERIOD_NS - 1) / `ABS_CLK_PERIOD_NS)

`endif

// ===== rtl/abs_pkg.sv
/*
  types for the converter scan cells.
  assumes abs_map.svh is on the include path.
*/
`include "abs_map.svh"
package abs_pkg;
  typedef logic [`ABS_NUM_CTRL-1:0] abs_ctrl_t;
  typedef logic [`ABS_DAC_BITS-1:0] abs_dac_t;
  typedef logic [7:0] abs_cnt_t;
endpackage

// ===== rtl/abs_scan_cells.sv
/*
  boundary-scan cells for the converter controls and comparator observe bit.
  assumes a test access controller drives the scan pins on its own clock,
  which is sampled here and edge-detected; capture is a level held around a
  test clock rising edge, update a level held around a falling edge.
*/
//
// Behaviour
// - every converter control and observe bit scanned
// - gain stages clocked from scanned clock
// - gain path enable links gain output
// - converter powered only while power-on high
// - amplifiers powered only while power-on high
// - ten-bit dac word, bit nine msb
// - bypass routes channels zero to three
// - ground enable grounds comparator negative input
// - hold low tracks, hold high keeps
`include "abs_map.svh"
module abs_scan_cells (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic TEST_CLK_IN,
  input wire logic SCAN_IN,
  input wire logic SHIFT_DR_IN,
  input wire logic CAPTURE_DR_IN,
  input wire logic UPDATE_DR_IN,
  input wire logic EXTEST_IN,
  input wire logic COMPARATOR_IN,
  input wire abs_pkg::abs_ctrl_t FUNC_CTRL_IN,
  output logic SCAN_OUT,
  output logic GAIN_STAGE_CLK_OUT,
  output logic GAIN_PATH_ENABLE_OUT,
  output logic BANDGAP_NEG_ENABLE_OUT,
  output logic CONVERTER_POWER_ON_OUT,
  output logic AMPLIFIER_POWER_ON_OUT,
  output abs_pkg::abs_dac_t DAC_WORD_OUT,
  output logic BYPASS_CHANNEL_ROUTE_OUT,
  output logic GAIN_X10_ENABLE_OUT,
  output logic GAIN_X20_ENABLE_OUT,
  output logic NEG_INPUT_GROUND_OUT,
  output logic HOLD_OUT,
  output logic INTERNAL_REF_ENABLE_OUT,
  output logic COMPARATOR_OUT,
  output logic SETTLED_OUT
);
  import abs_pkg::*;

  localparam int NSYNC = 7;
  localparam int CHAIN = `ABS_NUM_CTRL + 1;
  localparam abs_ctrl_t RST = `ABS_CTRL_RESET;

  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] pins_s;
  logic tck_s, tdi_s, shift_s, capt_s, upd_s, ext_s, comp_s;
  logic tck_prev_ff;
  logic [CHAIN-1:0] shift_ff;
  abs_ctrl_t upd_ff;
  abs_ctrl_t ctrl_sel;
  abs_cnt_t settle_ff;
  logic tck_rise, tck_fall;
  logic [CHAIN-1:0] nxt_shift;
  abs_ctrl_t nxt_upd;
  abs_cnt_t nxt_settle;
  logic conv_pwr;

  assign raw_pins = {COMPARATOR_IN, EXTEST_IN, UPDATE_DR_IN, CAPTURE_DR_IN,
                     SHIFT_DR_IN, SCAN_IN, TEST_CLK_IN};

  // every pin from the test controller and the analog comparator is resynced
  abs_sync #(.WIDTH(NSYNC), .RESET_VAL('0)) u_sync (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .d_in(raw_pins),
    .q_out(pins_s)
  );

  assign {comp_s, ext_s, upd_s, capt_s, shift_s, tdi_s, tck_s} = pins_s;
  assign tck_rise = tck_s & ~tck_prev_ff;
  assign tck_fall = ~tck_s & tck_prev_ff;

  // chain bit 0 is the comparator observe cell, then one cell per control
  assign nxt_shift = (tck_rise && shift_s) ? {tdi_s, shift_ff[CHAIN-1:1]} :
                     (tck_rise && capt_s) ? {upd_ff, comp_s} :
                     shift_ff;
  // update latch loads on the falling test clock edge of the update state
  assign nxt_upd = (tck_fall && upd_s) ? shift_ff[CHAIN-1:1] : upd_ff;

  // extest gives the chain control, otherwise the functional logic drives
  assign ctrl_sel = ext_s ? upd_ff : FUNC_CTRL_IN;
  assign conv_pwr = ctrl_sel[`ABS_POS_CONV_PWR];

  // settle counter restarts whenever the converter is off
  assign nxt_settle = !conv_pwr ? abs_cnt_t'(0) :
                      (settle_ff == abs_cnt_t'(`ABS_SETTLE_CYC)) ? settle_ff :
                      settle_ff + abs_cnt_t'(1);

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tck_prev_ff <= 1'b0;
      shift_ff <= {`ABS_CTRL_RESET, 1'b0};
      upd_ff <= `ABS_CTRL_RESET;
      settle_ff <= 8'h00;
    end else begin
      tck_prev_ff <= tck_s;
      shift_ff <= nxt_shift;
      upd_ff <= nxt_upd;
      settle_ff <= nxt_settle;
    end
  end

  // one short register per output; control resets come from the idle control word, scan, comparator and settled reset to 0
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SCAN_OUT <= 1'b0;
    end else begin
      SCAN_OUT <= shift_ff[0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GAIN_STAGE_CLK_OUT <= RST[`ABS_POS_GAIN_CLK];
    end else begin
      GAIN_STAGE_CLK_OUT <= ctrl_sel[`ABS_POS_GAIN_CLK];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GAIN_PATH_ENABLE_OUT <= RST[`ABS_POS_GAIN_PATH];
    end else begin
      GAIN_PATH_ENABLE_OUT <= ctrl_sel[`ABS_POS_GAIN_PATH];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      BANDGAP_NEG_ENABLE_OUT <= RST[`ABS_POS_BANDGAP_NEG];
    end else begin
      BANDGAP_NEG_ENABLE_OUT <= ctrl_sel[`ABS_POS_BANDGAP_NEG];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      CONVERTER_POWER_ON_OUT <= RST[`ABS_POS_CONV_PWR];
    end else begin
      CONVERTER_POWER_ON_OUT <= conv_pwr;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      AMPLIFIER_POWER_ON_OUT <= RST[`ABS_POS_AMP_PWR];
    end else begin
      AMPLIFIER_POWER_ON_OUT <= ctrl_sel[`ABS_POS_AMP_PWR];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      DAC_WORD_OUT <= `ABS_DAC_MIDSCALE;
    end else begin
      DAC_WORD_OUT <= ctrl_sel[`ABS_POS_DAC_LSB +: `ABS_DAC_BITS];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      BYPASS_CHANNEL_ROUTE_OUT <= RST[`ABS_POS_BYPASS];
    end else begin
      BYPASS_CHANNEL_ROUTE_OUT <= ctrl_sel[`ABS_POS_BYPASS];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GAIN_X10_ENABLE_OUT <= RST[`ABS_POS_GAIN_X10];
    end else begin
      GAIN_X10_ENABLE_OUT <= ctrl_sel[`ABS_POS_GAIN_X10];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GAIN_X20_ENABLE_OUT <= RST[`ABS_POS_GAIN_X20];
    end else begin
      GAIN_X20_ENABLE_OUT <= ctrl_sel[`ABS_POS_GAIN_X20];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      NEG_INPUT_GROUND_OUT <= RST[`ABS_POS_NEG_GND];
    end else begin
      NEG_INPUT_GROUND_OUT <= ctrl_sel[`ABS_POS_NEG_GND];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      HOLD_OUT <= RST[`ABS_POS_HOLD];
    end else begin
      HOLD_OUT <= ctrl_sel[`ABS_POS_HOLD];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      INTERNAL_REF_ENABLE_OUT <= RST[`ABS_POS_IREF];
    end else begin
      INTERNAL_REF_ENABLE_OUT <= ctrl_sel[`ABS_POS_IREF];
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      COMPARATOR_OUT <= 1'b0;
    end else begin
      COMPARATOR_OUT <= comp_s;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SETTLED_OUT <= 1'b0;
    end else begin
      SETTLED_OUT <= (settle_ff == abs_cnt_t'(`ABS_SETTLE_CYC));
    end
  end
endmodule

// ===== rtl/abs_sync.sv
/*
  two-stage synchroniser for a group of level inputs.
  assumes async active-high reset and inputs from outside the clock domain.
*/
module abs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_ff <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule
